// file: pkg/agsc_pkg.sv
// package: constants and carriers for address generation and stack checking
`default_nettype none
package agsc_pkg;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned NUM_WREGS     = 16;
  localparam int unsigned FADDR_W       = 13;
  localparam int unsigned PC_W          = 23;
  localparam int unsigned STATUS_LOW_W  = 8;
  localparam int unsigned RET_W         = 32;
  localparam int unsigned LIT5_W        = 5;
  localparam int unsigned LIT10_W       = 10;
  localparam logic [3:0]  SP_IDX        = 4'hf;
  localparam logic [3:0]  WORK0_IDX     = 4'h0;
  localparam logic [15:0] SP_UNDER_LIM  = 16'h0800;
  localparam logic [15:0] SP_RESET      = 16'h0800;
  localparam logic [15:0] WORD_STEP     = 16'h0002;
  localparam logic [15:0] BOUND_RESET   = 16'h0000;
  localparam logic [15:0] ALIGN_MASK    = 16'hfffe;

  // operand addressing modes
  typedef enum logic [2:0] {
    AGSC_M_FILE_DIRECT,
    AGSC_M_REG_DIRECT,
    AGSC_M_IND,
    AGSC_M_IND_POST,
    AGSC_M_IND_PRE,
    AGSC_M_IND_REG_OFS,
    AGSC_M_IND_LIT_OFS,
    AGSC_M_LITERAL
  } agsc_mode_t;

  // stack operations
  typedef enum logic [2:0] {
    AGSC_S_NONE,
    AGSC_S_PUSH,
    AGSC_S_POP,
    AGSC_S_CALL,
    AGSC_S_EXC
  } agsc_stack_op_t;

  // instruction classes
  typedef enum logic [1:0] {
    AGSC_C_FILE,
    AGSC_C_MOVE,
    AGSC_C_THREE_OP
  } agsc_class_t;

  // one operand request from the decoder
  typedef struct packed {
    logic           valid;
    agsc_class_t    iclass;
    agsc_mode_t     mode;
    logic [3:0]     pointer_reg;
    logic [3:0]     base_operand_reg;
    logic [15:0]    faddr;
    logic [9:0]     literal;
    logic           lit_long;
    logic           dec;
    logic [15:0]    step;
    logic           is_write;
    logic           to_file;
    logic           boot_code;
    logic           secure_code;
  } agsc_req_t;

  // answer to the pipeline
  typedef struct packed {
    logic           valid;
    logic           is_mem;
    logic [15:0]    ea;
    logic [15:0]    value;
    logic           blocked;
    logic [3:0]     dest_reg;
  } agsc_ans_t;
endpackage
`default_nettype wire

// file: rtl/agsc_core.sv
// address generation, software stack and secure ram gating
`default_nettype none
module agsc_core (
  input  wire logic                    i_core_clk,     // core clock, 20 MHz
  input  wire logic                    i_reset,        // async reset, active high
  input  wire agsc_pkg::agsc_req_t     i_req,          // operand request
  input  wire agsc_pkg::agsc_stack_op_t i_stack_op,    // stack operation
  input  wire logic [22:0]             i_pc,           // program counter to push
  input  wire logic [7:0]              i_status_low,   // status low byte
  input  wire logic [15:0]             i_pop_data,     // word read on a pop
  input  wire logic                    i_wr_bound,     // write stack upper bound
  input  wire logic                    i_wr_reg,       // write a working register
  input  wire logic [3:0]              i_wr_idx,       // register index
  input  wire logic [15:0]             i_wr_data,      // register data
  input  wire logic [15:0]             i_boot_ram_lo,  // boot secure ram start
  input  wire logic [15:0]             i_boot_ram_hi,  // boot secure ram end
  input  wire logic                    i_boot_ram_en,  // boot secure ram enable
  input  wire logic [15:0]             i_sec_ram_lo,   // secure ram start
  input  wire logic [15:0]             i_sec_ram_hi,   // secure ram end
  input  wire logic                    i_sec_ram_en,   // secure ram enable
  output logic                         o_ans_valid,    // answer valid
  output agsc_pkg::agsc_ans_t          o_ans,          // address answer
  output logic                         o_push_valid,   // stack write strobe
  output logic [15:0]                  o_push_addr,    // stack write address
  output logic [31:0]                  o_push_data,    // stack write data
  output logic                         o_pop_valid,    // stack read strobe
  output logic [15:0]                  o_pop_addr,     // stack read address
  output logic [15:0]                  o_pop_value,    // popped word
  output logic [15:0]                  o_sp,           // stack pointer
  output logic [15:0]                  o_bound,        // stack upper bound
  output logic                         o_trap_over,    // overflow trap pulse
  output logic                         o_trap_under    // underflow trap pulse
);

  ////////////////////////////////////////////////////////////////////////
  // working registers and stack upper bound
  logic [15:0] work_r   [agsc_pkg::NUM_WREGS];
  logic [15:0] work_nxt [agsc_pkg::NUM_WREGS];
  logic [15:0] bound_r, bound_nxt;
  logic [15:0] ptr, base, sp, lit, ea, upd, step_s;
  logic        ptr_wb, is_mem, blocked, ptr_is_sp;
  logic [15:0] push_addr, pop_addr, sp_after;
  logic        do_push, do_pop;
  logic [31:0] push_data;
  logic        over, under;
  agsc_pkg::agsc_ans_t ans_nxt;

  assign sp   = work_r[agsc_pkg::SP_IDX];
  assign ptr  = work_r[i_req.pointer_reg];
  assign base = work_r[i_req.base_operand_reg];
  // literal width select, 5 or 10 bits zero extended
  assign lit  = i_req.lit_long ? {6'h00, i_req.literal} : {11'h000, i_req.literal[4:0]};
  assign step_s = i_req.dec ? (16'h0000 - i_req.step) : i_req.step;
  // file-direct carries no pointer, so its stale pointer field must not trap
  assign ptr_is_sp = i_req.pointer_reg == agsc_pkg::SP_IDX
                  && i_req.mode != agsc_pkg::AGSC_M_FILE_DIRECT;

  // effective address per mode
  always_comb begin
    ea     = 16'h0000;
    upd    = ptr;
    ptr_wb = 1'b0;
    is_mem = 1'b1;
    unique case (i_req.mode)
      agsc_pkg::AGSC_M_FILE_DIRECT: begin
        if (i_req.iclass == agsc_pkg::AGSC_C_MOVE) begin
          ea = i_req.faddr;
        end else begin
          ea = {3'h0, i_req.faddr[agsc_pkg::FADDR_W-1:0]};
        end
      end
      agsc_pkg::AGSC_M_REG_DIRECT: begin
        is_mem = 1'b0;
      end
      agsc_pkg::AGSC_M_IND: begin
        ea = ptr;
      end
      agsc_pkg::AGSC_M_IND_POST: begin
        ea     = ptr;
        upd    = ptr + step_s;
        ptr_wb = 1'b1;
      end
      agsc_pkg::AGSC_M_IND_PRE: begin
        upd    = ptr + step_s;
        ea     = upd;
        ptr_wb = 1'b1;
      end
      agsc_pkg::AGSC_M_IND_REG_OFS: begin
        ea = ptr + base;
      end
      agsc_pkg::AGSC_M_IND_LIT_OFS: begin
        ea = ptr + lit;
      end
      agsc_pkg::AGSC_M_LITERAL: begin
        is_mem = 1'b0;
      end
    endcase
  end

  always_comb begin
    blocked = 1'b0;
    if (i_boot_ram_en && is_mem && ea >= i_boot_ram_lo && ea <= i_boot_ram_hi
        && !i_req.boot_code) begin
      blocked = 1'b1;
    end
    if (i_sec_ram_en && is_mem && ea >= i_sec_ram_lo && ea <= i_sec_ram_hi
        && !i_req.secure_code) begin
      blocked = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stack operations
  assign do_push = i_stack_op == agsc_pkg::AGSC_S_PUSH || i_stack_op == agsc_pkg::AGSC_S_CALL
                || i_stack_op == agsc_pkg::AGSC_S_EXC;
  assign do_pop  = i_stack_op == agsc_pkg::AGSC_S_POP;
  // push at pointer, pop at pointer minus a word
  assign push_addr = sp;
  assign pop_addr  = sp - agsc_pkg::WORD_STEP;
  assign sp_after  = do_push ? sp + (agsc_pkg::WORD_STEP << 1) * 16'(i_stack_op != agsc_pkg::AGSC_S_PUSH)
                   + agsc_pkg::WORD_STEP * 16'(i_stack_op == agsc_pkg::AGSC_S_PUSH)
                   : pop_addr;

  // return address formatting
  always_comb begin
    push_data = {16'h0000, i_wr_data};
    if (i_stack_op == agsc_pkg::AGSC_S_CALL) begin
      push_data = {9'h000, i_pc[22:0]};
    // exception places status byte above top bit
    end else if (i_stack_op == agsc_pkg::AGSC_S_EXC) begin
      push_data = {i_status_low, 1'b0, i_pc[22:0]};
    end else if (i_stack_op == agsc_pkg::AGSC_S_PUSH) begin
      push_data = {16'h0000, i_req.to_file ? i_req.faddr : work_r[agsc_pkg::WORK0_IDX]};
    end
  end

  // compare stack pointer addresses with the bound and the underflow limit
  always_comb begin
    over  = 1'b0;
    under = 1'b0;
    if (do_push && push_addr > bound_r) begin
      over = 1'b1;
    end
    if (i_req.valid && is_mem && ptr_is_sp && ea > bound_r) begin
      over = 1'b1;
    end
    if ((do_pop && pop_addr < agsc_pkg::SP_UNDER_LIM)
        || (i_req.valid && is_mem && ptr_is_sp && ea < agsc_pkg::SP_UNDER_LIM)) begin
      under = 1'b1;
    end
  end

  // register next values
  always_comb begin
    for (int k = 0; k < agsc_pkg::NUM_WREGS; k++) begin
      work_nxt[k] = work_r[k];
    end
    bound_nxt = bound_r;
    if (i_wr_reg) begin
      work_nxt[i_wr_idx] = i_wr_data;
    end
    if (i_req.valid && ptr_wb) begin
      work_nxt[i_req.pointer_reg] = upd;
    end
    // pointer moves to next free word
    if (do_push || do_pop) begin
      work_nxt[agsc_pkg::SP_IDX] = sp_after;
    end
    if (i_wr_bound) begin
      bound_nxt = i_wr_data & agsc_pkg::ALIGN_MASK;
    end
    work_nxt[agsc_pkg::SP_IDX] = work_nxt[agsc_pkg::SP_IDX] & agsc_pkg::ALIGN_MASK;
  end

  // answer next value
  always_comb begin
    ans_nxt          = '0;
    ans_nxt.valid    = i_req.valid;
    ans_nxt.is_mem   = is_mem;
    ans_nxt.ea       = ea;
    ans_nxt.blocked  = blocked;
    // file class result to default register, other classes to base field
    ans_nxt.dest_reg = (i_req.iclass == agsc_pkg::AGSC_C_FILE) ? agsc_pkg::WORK0_IDX
                                                               : i_req.base_operand_reg;
    unique case (i_req.mode)
      agsc_pkg::AGSC_M_LITERAL:    ans_nxt.value = lit;
      agsc_pkg::AGSC_M_REG_DIRECT: ans_nxt.value = (i_req.iclass == agsc_pkg::AGSC_C_THREE_OP)
                                                   ? base : ptr;
      default:                     ans_nxt.value = base;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state registers
  generate
    for (genvar g = 0; g < agsc_pkg::NUM_WREGS; g++) begin : g_work
      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          work_r[g] <= (g == agsc_pkg::SP_IDX) ? agsc_pkg::SP_RESET : 16'h0000;
        end else begin
          work_r[g] <= work_nxt[g];
        end
      end
    end
  endgenerate

  // outputs all registered
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      bound_r      <= agsc_pkg::BOUND_RESET;
      o_ans_valid  <= 1'b0;
      o_ans        <= '0;
      o_push_valid <= 1'b0;
      o_push_addr  <= 16'h0000;
      o_push_data  <= 32'h0000_0000;
      o_pop_valid  <= 1'b0;
      o_pop_addr   <= 16'h0000;
      o_pop_value  <= 16'h0000;
      o_sp         <= agsc_pkg::SP_RESET;
      o_bound      <= agsc_pkg::BOUND_RESET;
      o_trap_over  <= 1'b0;
      o_trap_under <= 1'b0;
    end else begin
      bound_r      <= bound_nxt;
      o_ans_valid  <= i_req.valid;
      o_ans        <= ans_nxt;
      o_push_valid <= do_push;
      o_push_addr  <= push_addr;
      o_push_data  <= push_data;
      o_pop_valid  <= do_pop;
      o_pop_addr   <= pop_addr;
      o_pop_value  <= i_pop_data;
      o_sp         <= work_nxt[agsc_pkg::SP_IDX];
      o_bound      <= bound_nxt;
      o_trap_over  <= over;
      o_trap_under <= under;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_bound_even: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_bound[0] == 1'b0) else $error("bound bit zero set");
  a_push_step: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_stack_op == agsc_pkg::AGSC_S_PUSH && !i_wr_reg) |=> o_sp == $past(sp) + 16'h0002)
    else $error("push did not step pointer");
  a_pop_addr: assert property (@(posedge i_core_clk) disable iff (i_reset)
    do_pop |=> o_pop_valid && o_pop_addr == $past(sp) - 16'h0002)
    else $error("pop address wrong");
  a_call_msb: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_stack_op == agsc_pkg::AGSC_S_CALL) |=> o_push_data[23] == 1'b0)
    else $error("call msb not clear");
  a_exc_status: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_stack_op == agsc_pkg::AGSC_S_EXC) |=> o_push_data[31:24] == $past(i_status_low))
    else $error("status byte missing");
  a_push_limit: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_stack_op == agsc_pkg::AGSC_S_PUSH && sp == bound_r && !i_req.valid) |=> !o_trap_over)
    else $error("trap at bound");
  a_under_trap: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (do_pop && sp < 16'h0802) |=> o_trap_under) else $error("underflow missed");
  a_boot_block: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_req.valid && i_boot_ram_en && is_mem && ea >= i_boot_ram_lo && ea <= i_boot_ram_hi
     && !i_req.boot_code) |=> o_ans.blocked) else $error("boot ram not blocked");
  a_pre_ea: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_req.valid && i_req.mode == agsc_pkg::AGSC_M_IND_PRE)
    |=> o_ans.ea == $past(ptr) + $past(step_s))
    else $error("pre mode address wrong");
  a_lit_ofs: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_req.valid && i_req.mode == agsc_pkg::AGSC_M_IND_LIT_OFS)
    |=> o_ans.ea == $past(ptr) + $past(lit))
    else $error("literal offset wrong");
  a_trap_pulse: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (do_push && sp > bound_r) |=> o_trap_over) else $error("overflow trap missing");

  c_push: cover property (@(posedge i_core_clk) disable iff (i_reset) o_push_valid);
  c_over: cover property (@(posedge i_core_clk) disable iff (i_reset) o_trap_over);
  c_under: cover property (@(posedge i_core_clk) disable iff (i_reset) o_trap_under);
  c_block: cover property (@(posedge i_core_clk) disable iff (i_reset) o_ans.blocked);

endmodule
`default_nettype wire

// file: tb/agsc_stack_mem.sv
// stack memory model standing on the pipeline side of the core
`default_nettype none
module agsc_stack_mem (
  input  wire logic        i_clk,        // core clock
  input  wire logic        i_push_valid, // stack write strobe
  input  wire logic [15:0] i_push_addr,  // stack write address
  input  wire logic [31:0] i_push_data,  // stack write data
  input  wire logic [15:0] i_sp,         // current stack pointer
  output logic      [15:0] o_rd_data     // word just below the pointer
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:32767];
  logic [15:0] rd_addr;

  ////////////////////////////////////////////////////////////////////////////
  // both halves stored; a plain push leaves the upper half above the top,
  // where it is never read before being overwritten
  always_ff @(posedge i_clk) begin
    if (i_push_valid) begin
      mem[i_push_addr[15:1]]         <= i_push_data[15:0];
      mem[i_push_addr[15:1] + 15'h1] <= i_push_data[31:16];
    end
  end

  // pop data offered for the word below the pointer
  assign rd_addr   = i_sp - 16'h0002;
  assign o_rd_data = mem[rd_addr[15:1]];
endmodule
`default_nettype wire

// file: tb/test_address_gen_stack_check.sv
// self-checking bench for address generation and stack checking
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module test_address_gen_stack_check;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       clk, rst, wr_bound, wr_reg, bs_en, ss_en;
  agsc_pkg::agsc_req_t        req;
  agsc_pkg::agsc_stack_op_t   sop;
  logic [22:0]                pc;
  logic [7:0]                 st_low;
  logic [3:0]                 wr_idx;
  logic [15:0]                wr_data, pop_data, bs_lo, bs_hi, ss_lo, ss_hi;
  logic                       ans_valid, push_valid, pop_valid, trap_over, trap_under;
  agsc_pkg::agsc_ans_t        ans;
  logic [15:0]                push_addr, pop_addr, pop_value, sp, bound;
  logic [31:0]                push_data;
  int                         mismatches, n_checks;

  agsc_core i_dut (.i_core_clk(clk), .i_reset(rst), .i_req(req), .i_stack_op(sop),
    .i_pc(pc), .i_status_low(st_low), .i_pop_data(pop_data), .i_wr_bound(wr_bound),
    .i_wr_reg(wr_reg), .i_wr_idx(wr_idx), .i_wr_data(wr_data), .i_boot_ram_lo(bs_lo),
    .i_boot_ram_hi(bs_hi), .i_boot_ram_en(bs_en), .i_sec_ram_lo(ss_lo),
    .i_sec_ram_hi(ss_hi), .i_sec_ram_en(ss_en), .o_ans_valid(ans_valid), .o_ans(ans),
    .o_push_valid(push_valid),
    .o_push_addr(push_addr), .o_push_data(push_data), .o_pop_valid(pop_valid),
    .o_pop_addr(pop_addr), .o_pop_value(pop_value), .o_sp(sp), .o_bound(bound),
    .o_trap_over(trap_over), .o_trap_under(trap_under));

  agsc_stack_mem i_mem (.i_clk(clk), .i_push_valid(push_valid), .i_push_addr(push_addr),
    .i_push_data(push_data), .i_sp(sp), .o_rd_data(pop_data));

  ////////////////////////////////////////////////////////////////////////////
  // clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog, far beyond the under 200 cycles the tests need
  initial begin
    #(50 * 5000);
    mismatches++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // drivers: change inputs 1 ns after the edge, answers seen one cycle on
  task automatic do_reset();
    rst = 1'b1;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
  endtask

  task automatic issue(input agsc_pkg::agsc_stack_op_t s, input agsc_pkg::agsc_req_t r);
    @(posedge clk);
    #1 sop = s;
    req = r;
    @(posedge clk);
    #1 sop = agsc_pkg::AGSC_S_NONE;
    req = '0;
  endtask

  task automatic wr(input logic b, input logic [3:0] idx, input logic [15:0] d);
    @(posedge clk);
    #1 wr_bound = b;
    wr_reg = ~b;
    wr_idx = idx;
    wr_data = d;
    @(posedge clk);
    #1 wr_bound = 1'b0;
    wr_reg = 1'b0;
    // keep stack pointer reads off the cycle after a write
    @(posedge clk);
  endtask

  function automatic agsc_pkg::agsc_req_t mk(agsc_pkg::agsc_mode_t m,
      agsc_pkg::agsc_class_t c, logic [3:0] p, logic [3:0] b);
    agsc_pkg::agsc_req_t r;
    r = '0;
    r.valid = 1'b1;
    r.mode = m;
    r.iclass = c;
    r.pointer_reg = p;
    r.base_operand_reg = b;
    r.step = agsc_pkg::WORD_STEP;
    return r;
  endfunction

  task automatic ea_chk(input agsc_pkg::agsc_req_t r, input logic [15:0] e);
    issue(agsc_pkg::AGSC_S_NONE, r);
    `CHK("ans_valid", 1'b1, ans_valid)
    `CHK("ea", e, ans.ea)
  endtask

  task automatic blk_chk(input agsc_pkg::agsc_req_t r, input logic e);
    issue(agsc_pkg::AGSC_S_NONE, r);
    `CHK("blocked", e, ans.blocked)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_stack();
    do_reset();
    `CHK("sp reset", 16'h0800, sp)
    issue(agsc_pkg::AGSC_S_PUSH, '0);
    `CHK("push valid", 1'b1, push_valid)
    `CHK("push addr", 16'h0800, push_addr)
    `CHK("sp after push", 16'h0802, sp)
    pc = 23'h7abcde;
    issue(agsc_pkg::AGSC_S_CALL, '0);
    `CHK("call addr", 16'h0802, push_addr)
    `CHK("call data", {9'h000, 23'h7abcde}, push_data)
    `CHK("sp after call", 16'h0806, sp)
    issue(agsc_pkg::AGSC_S_POP, '0);
    `CHK("pop valid", 1'b1, pop_valid)
    `CHK("pop addr", 16'h0804, pop_addr)
    `CHK("pop value", 16'h007a, pop_value)
    `CHK("sp after pop", 16'h0804, sp)
    pc = 23'h7fffff;
    st_low = 8'hc3;
    issue(agsc_pkg::AGSC_S_EXC, '0);
    `CHK("exc addr", 16'h0804, push_addr)
    `CHK("exc data", {8'hc3, 1'b0, 23'h7fffff}, push_data)
    $display("test stack done");
  endtask

  task automatic test_bound();
    do_reset();
    wr(1'b1, 4'h0, 16'h0805);
    `CHK("bound bit0", 16'h0804, bound)
    for (int i = 0; i < 4; i++) begin
      issue(agsc_pkg::AGSC_S_PUSH, '0);
      `CHK("overflow", (i == 3), trap_over)
    end
    @(posedge clk);
    #1 `CHK("overflow pulse", 1'b0, trap_over)
    do_reset();
    issue(agsc_pkg::AGSC_S_POP, '0);
    `CHK("underflow", 1'b1, trap_under)
    `CHK("under addr", 16'h07fe, pop_addr)
    @(posedge clk);
    #1 `CHK("underflow pulse", 1'b0, trap_under)
    $display("test bound done");
  endtask

  task automatic test_sp_ea();
    do_reset();
    wr(1'b1, 4'h0, 16'h0900);
    wr(1'b0, agsc_pkg::SP_IDX, 16'h0a00);
    ea_chk(mk(agsc_pkg::AGSC_M_IND, agsc_pkg::AGSC_C_MOVE, agsc_pkg::SP_IDX, 4'h0), 16'h0a00);
    `CHK("sp ea over", 1'b1, trap_over)
    wr(1'b0, agsc_pkg::SP_IDX, 16'h0700);
    issue(agsc_pkg::AGSC_S_NONE,
      mk(agsc_pkg::AGSC_M_IND, agsc_pkg::AGSC_C_MOVE, agsc_pkg::SP_IDX, 4'h0));
    `CHK("sp ea under", 1'b1, trap_under)
    $display("test sp ea done");
  endtask

  task automatic test_modes();
    agsc_pkg::agsc_req_t r;
    do_reset();
    wr(1'b0, 4'h1, 16'h1000);
    wr(1'b0, 4'h2, 16'h0010);
    ea_chk(mk(agsc_pkg::AGSC_M_IND, agsc_pkg::AGSC_C_MOVE, 4'h1, 4'h0), 16'h1000);
    ea_chk(mk(agsc_pkg::AGSC_M_IND_POST, agsc_pkg::AGSC_C_MOVE, 4'h1, 4'h0), 16'h1000);
    ea_chk(mk(agsc_pkg::AGSC_M_IND, agsc_pkg::AGSC_C_MOVE, 4'h1, 4'h0), 16'h1002);
    r = mk(agsc_pkg::AGSC_M_IND_PRE, agsc_pkg::AGSC_C_MOVE, 4'h1, 4'h0);
    r.dec = 1'b1;
    ea_chk(r, 16'h1000);
    ea_chk(mk(agsc_pkg::AGSC_M_IND_REG_OFS, agsc_pkg::AGSC_C_MOVE, 4'h1, 4'h2), 16'h1010);
    r = mk(agsc_pkg::AGSC_M_IND_LIT_OFS, agsc_pkg::AGSC_C_MOVE, 4'h1, 4'h0);
    r.literal = 10'h006;
    ea_chk(r, 16'h1006);
    // base field set apart from the default register so the destination choice shows
    r = mk(agsc_pkg::AGSC_M_FILE_DIRECT, agsc_pkg::AGSC_C_FILE, 4'h0, 4'h5);
    r.faddr = 16'hffff;
    ea_chk(r, 16'h1fff);
    `CHK("default dest", agsc_pkg::WORK0_IDX, ans.dest_reg)
    r.iclass = agsc_pkg::AGSC_C_MOVE;
    ea_chk(r, 16'hffff);
    r = mk(agsc_pkg::AGSC_M_LITERAL, agsc_pkg::AGSC_C_THREE_OP, 4'h0, 4'h0);
    r.literal = 10'h3ff;
    issue(agsc_pkg::AGSC_S_NONE, r);
    `CHK("lit5", 16'h001f, ans.value)
    `CHK("lit not memory", 1'b0, ans.is_mem)
    r.lit_long = 1'b1;
    issue(agsc_pkg::AGSC_S_NONE, r);
    `CHK("lit10", 16'h03ff, ans.value)
    // pointer field names another register, so only the base register may answer
    issue(agsc_pkg::AGSC_S_NONE,
      mk(agsc_pkg::AGSC_M_REG_DIRECT, agsc_pkg::AGSC_C_THREE_OP, 4'h2, 4'h1));
    `CHK("base direct", 16'h1000, ans.value)
    $display("test modes done");
  endtask

  task automatic test_secure();
    agsc_pkg::agsc_req_t r;
    do_reset();
    wr(1'b0, 4'h1, 16'h1000);
    wr(1'b0, 4'h3, 16'h2000);
    r = mk(agsc_pkg::AGSC_M_IND, agsc_pkg::AGSC_C_MOVE, 4'h1, 4'h0);
    blk_chk(r, 1'b1);
    r.boot_code = 1'b1;
    blk_chk(r, 1'b0);
    r = mk(agsc_pkg::AGSC_M_IND, agsc_pkg::AGSC_C_MOVE, 4'h3, 4'h0);
    blk_chk(r, 1'b1);
    r.secure_code = 1'b1;
    blk_chk(r, 1'b0);
    bs_en = 1'b0;
    blk_chk(mk(agsc_pkg::AGSC_M_IND, agsc_pkg::AGSC_C_MOVE, 4'h1, 4'h0), 1'b0);
    $display("test secure done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {wr_bound, wr_reg, wr_idx, wr_data, pc, st_low} = '0;
    req = '0;
    sop = agsc_pkg::AGSC_S_NONE;
    {bs_lo, bs_hi, bs_en} = {16'h1000, 16'h10ff, 1'b1};
    {ss_lo, ss_hi, ss_en} = {16'h2000, 16'h20ff, 1'b1};
    mismatches = 0;
    n_checks = 0;
    test_stack();
    test_bound();
    test_sp_ea();
    test_modes();
    test_secure();
    stop_test();
  end
endmodule
`undef CHK
`default_nettype wire
